// ---- hdl/divc_pkg.sv ----
package divc_pkg;

   // ************************************************************
   // sizes and vector layout
   // ************************************************************
   localparam int         NUM_IRQ      = 32;
   localparam int         NUM_W        = 5;
   localparam int         SLOT_LSB_W   = 3;
   localparam int         LOW_W        = 16;
   localparam int         HIGH_W       = 11;
   localparam int         HIGH_FIRST   = 16;
   localparam logic [4:0] NUM_RESET    = 5'h00;
   localparam logic [4:0] NUM_HOST_LO  = 5'h10;
   localparam logic [4:0] NUM_HOST_HI  = 5'h17;

   // ************************************************************
   // register offsets (byte addresses, one word each)
   // ************************************************************
   localparam logic [7:0] OFS_FLAGS_LOW  = 8'h00;
   localparam logic [7:0] OFS_EN_LOW     = 8'h04;
   localparam logic [7:0] OFS_FLAGS_HIGH = 8'h08;
   localparam logic [7:0] OFS_EN_HIGH    = 8'h0c;
   localparam logic [7:0] OFS_DATA_BASE  = 8'h10;
   localparam logic [7:0] OFS_HOST_BASE  = 8'h14;
   localparam logic [7:0] OFS_CTRL       = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h1c;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLR    = 8'h24;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h28;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam logic [15:0] LOW_MASK    = 16'hfbfc;
   localparam logic [10:0] HIGH_MASK   = 11'h7ff;
   localparam logic [15:0] RST_LOW     = 16'h0000;
   localparam logic [10:0] RST_HIGH    = 11'h000;
   localparam int          BIT_PIN0    = 2;
   localparam int          BIT_PIN1    = 3;
   localparam int          BIT_PROG_B_TX = 9;
   localparam int          BIT_PROG_B_RX = 11;
   localparam logic [1:0]  MODE_CARD   = 2'h0;
   localparam logic [1:0]  MODE_SPI    = 2'h1;
   localparam int          IRQ_W       = 3;
   localparam int          EV_ACK      = 0;
   localparam int          EV_WAKE     = 1;
   localparam int          EV_PIN      = 2;

   // ************************************************************
   // fixed priority value per interrupt number, 31 down to 0
   // ************************************************************
   localparam logic [31:0][4:0] PRIO = {
      5'd18, 5'd17, 5'd16, 5'd15, 5'd14, 5'd26, 5'd25, 5'd2,
      5'd24, 5'd23, 5'd20, 5'd19, 5'd16, 5'd12, 5'd8,  5'd4,
      5'd22, 5'd21, 5'd18, 5'd17, 5'd15, 5'd14, 5'd13, 5'd11,
      5'd10, 5'd9,  5'd7,  5'd6,  5'd5,  5'd3,  5'd1,  5'd0
   };

endpackage

// ---- hdl/divc_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_pin_sync (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic pin_n_i,
   output logic      fall_o
);
   import divc_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic fall;
   } divc_sync_t;

   divc_sync_t s;
   divc_sync_t next_s;

   // ************************************************************
   // three stages; a level counts once stages two and three agree
   // ************************************************************
   always_comb begin
      next_s      = s;
      next_s.s1   = pin_n_i;
      next_s.s2   = s.s1;
      next_s.s3   = s.s2;
      next_s.fall = 1'b0;
      if (s.s2 == s.s3) begin
         next_s.level = s.s3;
         next_s.fall  = s.level & ~s.s3;
      end
   end

   // idle line is high, so the chain resets to ones
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, fall: 1'b0};
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign fall_o = s.fall;
endmodule
`default_nettype wire

// ---- hdl/divc_arbiter.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_arbiter #(
   parameter int N = 32
) (
   input  wire logic [N-1:0] pending_i,
   output logic              any_o,
   output logic [4:0]        num_o
);
   import divc_pkg::*;

   if (N < 1 || N > NUM_IRQ) begin : g_bad_n
      $error("arbiter width out of range");
   end

   logic [4:0] best;

   // ************************************************************
   // lowest priority value wins; ties go to the lower number
   // ************************************************************
   always_comb begin
      any_o = 1'b0;
      num_o = 5'h00;
      best  = 5'h1f;
      for (int i = 0; i < N; i++) begin
         if (pending_i[i] && (!any_o || PRIO[i] < best)) begin
            any_o = 1'b1;
            num_o = 5'(i);
            best  = PRIO[i];
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/divc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_top #(
   parameter int BASE_W = 16
) (
   input  wire logic                 clock_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   // external pins, active low
   input  wire logic                 pin_irq_zero_n_i,
   input  wire logic                 pin_irq_one_n_i,
   // peripheral sources, level high
   input  wire logic                 timer_aggregate_irq_i,
   input  wire logic                 programmable_tx_source_a_i,
   input  wire logic                 uart_irq_i,
   input  wire logic                 programmable_rx_source_a_i,
   input  wire logic                 dma_irq_i,
   input  wire logic                 card1_irq_i,
   input  wire logic                 multichannel_spi_irq_i,
   input  wire logic                 card1_sdio_irq_i,
   input  wire logic                 host_port_irq_i,
   input  wire logic                 converter_irq_i,
   input  wire logic                 audio2_transmit_irq_i,
   input  wire logic                 audio2_receive_irq_i,
   input  wire logic                 audio3_transmit_irq_i,
   input  wire logic                 audio3_receive_irq_i,
   input  wire logic                 wake_clock_irq_i,
   input  wire logic                 spi_irq_i,
   input  wire logic                 usb_irq_i,
   input  wire logic                 gpio_irq_i,
   input  wire logic                 memory_interface_fault_irq_i,
   input  wire logic                 i2c_irq_i,
   input  wire logic                 bus_fault_irq_i,
   input  wire logic                 data_logging_irq_i,
   input  wire logic                 os_kernel_irq_i,
   // core side
   input  wire logic                 soft_reset_i,
   input  wire logic                 idle_req_i,
   input  wire logic                 int_ack_i,
   input  wire logic [4:0]           trap_num_i,
   output logic                      int_req_o,
   output logic [4:0]                int_number_o,
   output logic [BASE_W+7:0]         int_vector_o,
   output logic [BASE_W+7:0]         trap_vector_o,
   output logic                      idle_o,
   output logic                      wake_o,
   output logic                      irq_o
);
   import divc_pkg::*;

   if (BASE_W < 1 || BASE_W > 24) begin : g_bad_base
      $error("vector base width out of range");
   end

   localparam int VEC_W = BASE_W + NUM_W + SLOT_LSB_W;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [LOW_W-1:0]  flags_low;
      logic [LOW_W-1:0]  en_low;
      logic [HIGH_W-1:0] flags_high;
      logic [HIGH_W-1:0] en_high;
      logic [BASE_W-1:0] data_base;
      logic [BASE_W-1:0] host_base;
      logic [1:0]        port_mode;
      logic              reset_pend;
      logic              idle;
      logic              wake;
      logic              req;
      logic [4:0]        num;
      logic [VEC_W-1:0]  vec;
      logic [VEC_W-1:0]  trap_vec;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_en;
      logic              ack;
      logic [31:0]       rdata;
   } divc_state_t;

   // reset counts as a pending number zero from the first edge on
   localparam divc_state_t STATE_RST = '{reset_pend: 1'b1, default: '0};

   divc_state_t s;
   divc_state_t next_s;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [VEC_W-1:0] vector_of(
      input logic [BASE_W-1:0] dbase,
      input logic [BASE_W-1:0] hbase,
      input logic [4:0]        num
   );
      logic [BASE_W-1:0] base;
      base = (num >= NUM_HOST_LO && num <= NUM_HOST_HI) ? hbase : dbase;
      return {base, num, {SLOT_LSB_W{1'b0}}};
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] dat,
      input logic [3:0]  sel
   );
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat & m);
   endfunction

   // ************************************************************
   // pins and arbitration
   // ************************************************************
   logic             pin0_fall;
   logic             pin1_fall;
   logic             arb_any;
   logic [4:0]       arb_num;
   logic [NUM_IRQ-1:0] pending;

   // the detector wants two high then two low samples per pulse
   divc_pin_sync u_pin0 (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_n_i (pin_irq_zero_n_i),
      .fall_o  (pin0_fall)
   );

   divc_pin_sync u_pin1 (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_n_i (pin_irq_one_n_i),
      .fall_o  (pin1_fall)
   );

   // bit 1 is the non-maskable slot and never requests
   assign pending = {5'h00, s.flags_high & s.en_high,
                     (s.flags_low & s.en_low) | {15'h0000, s.reset_pend}};

   divc_arbiter #(
      .N (NUM_IRQ)
   ) u_arb (
      .pending_i (pending),
      .any_o     (arb_any),
      .num_o     (arb_num)
   );

   // ************************************************************
   // next state
   // ************************************************************
   logic              req_cyc;
   logic              wr;
   logic              acked;
   logic              wake_any;
   logic [31:0]       ack_hot;
   logic [LOW_W-1:0]  set_low;
   logic [LOW_W-1:0]  clr_low;
   logic [HIGH_W-1:0] set_high;
   logic [HIGH_W-1:0] clr_high;
   logic [IRQ_W-1:0]  ev;
   logic [IRQ_W-1:0]  ev_clr;
   logic [31:0]       rd;
   logic [31:0]       wv;

   always_comb begin
      next_s   = s;
      req_cyc  = wb_cyc_i & wb_stb_i;
      wr       = req_cyc & wb_we_i & s.ack;
      acked    = s.req & int_ack_i;
      ack_hot  = acked ? (32'h0000_0001 << s.num) : 32'h0000_0000;
      wake_any = |(s.flags_low & s.en_low) | |(s.flags_high & s.en_high);
      wv       = 32'h0000_0000;
      ev_clr   = '0;

      // sources into flag bits; low bit b is number b
      set_low                = '0;
      set_low[BIT_PIN0]      = pin0_fall;
      set_low[BIT_PIN1]      = pin1_fall;
      set_low[4]             = timer_aggregate_irq_i;
      set_low[5]             = programmable_tx_source_a_i;
      set_low[6]             = uart_irq_i;
      set_low[7]             = programmable_rx_source_a_i;
      set_low[8]             = dma_irq_i;
      set_low[12]            = host_port_irq_i;
      set_low[13]            = converter_irq_i;
      set_low[14]            = audio2_transmit_irq_i;
      set_low[15]            = audio2_receive_irq_i;
      case (s.port_mode)
         MODE_CARD: begin
            set_low[BIT_PROG_B_TX] = card1_irq_i;
            set_low[BIT_PROG_B_RX] = card1_sdio_irq_i;
         end
         MODE_SPI: begin
            set_low[BIT_PROG_B_TX] = multichannel_spi_irq_i;
            set_low[BIT_PROG_B_RX] = 1'b1;
         end
         default: begin
            set_low[BIT_PROG_B_TX] = 1'b0;
            set_low[BIT_PROG_B_RX] = 1'b0;
         end
      endcase
      set_high = {os_kernel_irq_i, data_logging_irq_i, bus_fault_irq_i, i2c_irq_i,
                  memory_interface_fault_irq_i, gpio_irq_i, usb_irq_i, spi_irq_i,
                  wake_clock_irq_i, audio3_receive_irq_i, audio3_transmit_irq_i};

      // acknowledge clears the flag that was dispatched
      clr_low  = ack_hot[LOW_W-1:0];
      clr_high = ack_hot[HIGH_FIRST +: HIGH_W];

      // bus writes land on the edge where ack is seen
      if (wr) begin
         case (wb_adr_i)
            OFS_FLAGS_LOW: begin
               wv      = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
               clr_low = clr_low | wv[LOW_W-1:0];
            end
            OFS_FLAGS_HIGH: begin
               wv       = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
               clr_high = clr_high | wv[HIGH_W-1:0];
            end
            OFS_EN_LOW: begin
               wv          = merge({16'h0000, s.en_low}, wb_dat_i, wb_sel_i);
               next_s.en_low = wv[LOW_W-1:0] & LOW_MASK;
            end
            OFS_EN_HIGH: begin
               wv           = merge({21'h000000, s.en_high}, wb_dat_i, wb_sel_i);
               next_s.en_high = wv[HIGH_W-1:0] & HIGH_MASK;
            end
            OFS_DATA_BASE: begin
               wv = merge(32'(s.data_base), wb_dat_i, wb_sel_i);
               next_s.data_base = wv[BASE_W-1:0];
            end
            OFS_HOST_BASE: begin
               wv = merge(32'(s.host_base), wb_dat_i, wb_sel_i);
               next_s.host_base = wv[BASE_W-1:0];
            end
            OFS_CTRL: begin
               wv = merge({30'h00000000, s.port_mode}, wb_dat_i, wb_sel_i);
               next_s.port_mode = wv[1:0];
            end
            OFS_IRQ_CLR: begin
               ev_clr = wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}};
            end
            OFS_IRQ_EN: begin
               wv = merge({29'h00000000, s.irq_en}, wb_dat_i, wb_sel_i);
               next_s.irq_en = wv[IRQ_W-1:0];
            end
            default: begin
               wv = 32'h0000_0000;
            end
         endcase
      end

      // a source that fires during its own clear is kept
      next_s.flags_low  = ((s.flags_low & ~clr_low) | set_low) & LOW_MASK;
      next_s.flags_high = ((s.flags_high & ~clr_high) | set_high) & HIGH_MASK;

      // soft reset re-arms number zero; acknowledge of zero retires it
      if (acked && s.num == NUM_RESET) begin
         next_s.reset_pend = 1'b0;
      end
      if (soft_reset_i) begin
         next_s.reset_pend = 1'b1;
      end

      // idle: only an enabled flag ends it, then the request goes out
      next_s.wake = 1'b0;
      if (s.idle) begin
         if (wake_any) begin
            next_s.idle = 1'b0;
            next_s.wake = 1'b1;
         end
      end else if (idle_req_i) begin
         next_s.idle = 1'b1;
      end

      // dispatch; request drops for a cycle after each acknowledge
      next_s.req = arb_any & ~s.idle & ~acked;
      next_s.num = arb_num;
      next_s.vec = vector_of(s.data_base, s.host_base, arb_num);
      next_s.trap_vec = vector_of(s.data_base, s.host_base, trap_num_i);

      // own events into sticky status
      ev          = '0;
      ev[EV_ACK]  = acked;
      ev[EV_WAKE] = s.idle & wake_any;
      ev[EV_PIN]  = pin0_fall | pin1_fall;
      next_s.irq_stat = (s.irq_stat & ~ev_clr) | ev;

      // read data is captured before ack so it is stable with it
      next_s.ack = req_cyc & ~s.ack;
      if (req_cyc && !s.ack && !wb_we_i) begin
         case (wb_adr_i)
            OFS_FLAGS_LOW:  rd = {16'h0000, s.flags_low};
            OFS_EN_LOW:     rd = {16'h0000, s.en_low};
            OFS_FLAGS_HIGH: rd = {21'h000000, s.flags_high};
            OFS_EN_HIGH:    rd = {21'h000000, s.en_high};
            OFS_DATA_BASE:  rd = 32'(s.data_base);
            OFS_HOST_BASE:  rd = 32'(s.host_base);
            OFS_CTRL:       rd = {30'h00000000, s.port_mode};
            OFS_STATUS:     rd = {24'h000000, s.idle, s.req, 1'b0, s.num};
            OFS_IRQ_STAT:   rd = {29'h00000000, s.irq_stat};
            OFS_IRQ_EN:     rd = {29'h00000000, s.irq_en};
            default:        rd = 32'h0000_0000;
         endcase
         next_s.rdata = rd;
      end else begin
         rd = 32'h0000_0000;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   // async reset also drops idle and every flag and enable
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s <= STATE_RST;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wb_ack_o      = s.ack & wb_cyc_i & wb_stb_i;
   assign wb_dat_o      = s.rdata;
   assign int_req_o     = s.req;
   assign int_number_o  = s.num;
   assign int_vector_o  = s.vec;
   assign trap_vector_o = s.trap_vec;
   assign idle_o        = s.idle;
   assign wake_o        = s.wake;
   assign irq_o         = |(s.irq_stat & s.irq_en);
endmodule
`default_nettype wire

// ---- test/divc_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_chk #(
   parameter int BASE_W = 16
) (
   input wire logic              clock_i,
   input wire logic              rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_ack_o,
   input wire logic              int_ack_i,
   input wire logic              int_req_o,
   input wire logic [4:0]        int_number_o,
   input wire logic [BASE_W+7:0] int_vector_o,
   input wire logic              idle_o,
   input wire logic              wake_o
);
   // ***
   // port relations
   // ***
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_vec_slot: assert property (int_req_o |-> int_vector_o[7:0] == {int_number_o, 3'h0})
      else $error("vector slot offset wrong");
   a_no_nmi: assert property (int_req_o |-> int_number_o != 5'h01)
      else $error("number one requested");
   a_idle_quiet: assert property (idle_o && $past(idle_o) |-> !int_req_o)
      else $error("request while idle");
   a_wake_cause: assert property (wake_o |-> $past(idle_o) && !idle_o)
      else $error("wake without idle");
   a_wake_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   a_ack_drops: assert property (int_req_o && int_ack_i |=> !int_req_o)
      else $error("request stays after accept");
   c_accept: cover property (int_req_o && int_ack_i);
   c_wake: cover property (wake_o);
   c_bus: cover property (wb_ack_o);
endmodule
bind divc_top divc_chk #(.BASE_W(BASE_W)) u_chk (.clock_i(clock_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .int_ack_i(int_ack_i),
   .int_req_o(int_req_o), .int_number_o(int_number_o), .int_vector_o(int_vector_o),
   .idle_o(idle_o), .wake_o(wake_o));
`default_nettype wire

// ---- test/divc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_core_model (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       int_req_i,
   input  wire logic [3:0] wait_i,
   output logic            int_ack_o
);
   // ***
   // core accepting requests after wait_i cycles; 15 holds them off
   // ***
   logic [3:0] cnt;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
         int_ack_o <= 1'b0;
      end else begin
         int_ack_o <= 1'b0;
         // no second accept: the request drops for a cycle after one
         if (!int_req_i || int_ack_o || wait_i == 4'hf) begin
            cnt <= 4'h0;
         end else if (cnt == wait_i) begin
            int_ack_o <= 1'b1;
            cnt <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/divc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module divc_top_tb;
   import divc_pkg::*;
   // ***
   // stimulus and reference state
   // ***
   logic        clock_i, rst_i, cyc, stb, we, idl, srst, ack, req, idle, wake, irq, iack;
   logic [1:0]  pn;
   logic [3:0]  dly;
   logic [4:0]  trap, num;
   logic [7:0]  adr;
   logic [15:0] dbase, hbase;
   logic [23:0] vec, tvec;
   logic [26:0] src;
   logic [31:0] dat, q, rd, pend, en, c;
   int          bad_count, n_tests, seed, k;
   int pr[32] = '{0, 1, 3, 5, 6, 7, 9, 10, 11, 13, 14, 15, 17, 18, 21, 22,
                  4, 8, 12, 16, 19, 20, 23, 24, 2, 25, 26, 14, 15, 16, 17, 18};
   divc_top dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
      .pin_irq_zero_n_i(pn[0]), .pin_irq_one_n_i(pn[1]), .timer_aggregate_irq_i(src[4]),
      .programmable_tx_source_a_i(src[5]), .uart_irq_i(src[6]),
      .programmable_rx_source_a_i(src[7]), .dma_irq_i(src[8]), .card1_irq_i(src[9]),
      .multichannel_spi_irq_i(src[10]), .card1_sdio_irq_i(src[11]), .host_port_irq_i(src[12]),
      .converter_irq_i(src[13]), .audio2_transmit_irq_i(src[14]), .audio2_receive_irq_i(src[15]),
      .audio3_transmit_irq_i(src[16]), .audio3_receive_irq_i(src[17]),
      .wake_clock_irq_i(src[18]), .spi_irq_i(src[19]), .usb_irq_i(src[20]), .gpio_irq_i(src[21]),
      .memory_interface_fault_irq_i(src[22]), .i2c_irq_i(src[23]), .bus_fault_irq_i(src[24]),
      .data_logging_irq_i(src[25]), .os_kernel_irq_i(src[26]), .soft_reset_i(srst),
      .idle_req_i(idl), .int_ack_i(iack), .trap_num_i(trap), .int_req_o(req), .int_number_o(num),
      .int_vector_o(vec), .trap_vector_o(tvec), .idle_o(idle), .wake_o(wake), .irq_o(irq));
   divc_core_model core (.clock_i(clock_i), .rst_i(rst_i), .int_req_i(req), .wait_i(dly),
      .int_ack_o(iack));
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = q;
      chk({31'h0, ack}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // sources pulse for one cycle; mode one moves bit 10 into bit 9 and pins bit 11 high
   task automatic fire(input logic [26:0] s, input logic m);
      @(posedge clock_i);
      src <= s;
      @(posedge clock_i);
      src <= 27'h0;
      pend |= m ? (32'(s & 27'h7fff1f0) | (32'(s[10]) << 9) | 32'h800) : 32'(s & 27'h7fffbf0);
   endtask
   task automatic pin(input int b);
      @(posedge clock_i);
      pn[b] <= 1'b0;
      repeat (3) @(posedge clock_i);
      pn[b] <= 1'b1;
      repeat (5) @(posedge clock_i);
      pend[2 + b] = 1'b1;
   endtask
   task automatic drain;
      int n, w, b;
      while ((pend & en) != 0) begin
         b = -1;
         for (n = 0; n < 32; n++) if (pend[n] && en[n] && (b < 0 || pr[n] < pr[b])) b = n;
         w = 0;
         do begin
            @(negedge clock_i);
            w++;
         end while (!(req === 1'b1 && iack === 1'b1) && w < 60);
         chk(32'(req & iack), 32'h1);
         chk(32'(num), 32'(b));
         chk(32'(vec), 32'({(b >= 16 && b <= 23) ? hbase : dbase, b[4:0], 3'h0}));
         pend[b] = 1'b0;
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock_i);
      bad_count++;
      end_sim;
   end
   initial begin
      seed = 26;
      bad_count = 0;
      n_tests = 0;
      {rst_i, cyc, stb, we, adr, dat, src, idl, srst} = '0;
      rst_i = 1'b1;
      pn = 2'b11;
      dly = 4'hf;
      trap = 5'h01;
      pend = 32'h1;
      en = 32'h1;
      {dbase, hbase} = '0;
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      for (k = 0; k < 4; k++) rdc(8'(4 * k), 32'h0);
      rdc(8'h3c, 32'h0);
      chk(32'(tvec[7:0]), 32'h8);
      dly <= 4'h0;
      drain;
      bus(1'b1, OFS_EN_LOW, 32'hfbff);
      rdc(OFS_EN_LOW, 32'hfbfc);
      bus(1'b1, OFS_EN_HIGH, 32'h7ff);
      en = 32'h7fffbfd;
      dbase = 16'($random(seed));
      hbase = 16'($random(seed));
      bus(1'b1, OFS_DATA_BASE, 32'(dbase));
      bus(1'b1, OFS_HOST_BASE, 32'(hbase));
      chk(32'(tvec), 32'({dbase, 5'h01, 3'h0}));
      for (k = 0; k < 6; k++) begin
         dly <= 4'hf;
         fire(27'($random(seed)), 1'b0);
         pin(k % 2);
         rdc(OFS_FLAGS_LOW, 32'(pend[15:0]));
         rdc(OFS_FLAGS_HIGH, 32'(pend[26:16]));
         c = $random(seed) & 32'hfbfc;
         bus(1'b1, OFS_FLAGS_LOW, c);
         pend &= ~c;
         rdc(OFS_FLAGS_LOW, 32'(pend[15:0]));
         dly <= 4'($random(seed) & 3);
         drain;
      end
      rdc(OFS_IRQ_STAT, 32'h5);
      bus(1'b1, OFS_IRQ_EN, 32'h1);
      @(negedge clock_i) chk(32'(irq), 32'h1);
      bus(1'b1, OFS_IRQ_EN, 32'h0);
      @(negedge clock_i) chk(32'(irq), 32'h0);
      bus(1'b1, OFS_IRQ_CLR, 32'h7);
      rdc(OFS_IRQ_STAT, 32'h0);
      dly <= 4'hf;
      bus(1'b1, OFS_CTRL, 32'h1);
      fire(27'($random(seed)), 1'b1);
      rdc(OFS_FLAGS_LOW, 32'(pend[15:0]));
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_FLAGS_LOW, 32'hfbfc);
      bus(1'b1, OFS_FLAGS_HIGH, 32'h7ff);
      pend = 32'h0;
      bus(1'b1, OFS_EN_LOW, 32'h10);
      bus(1'b1, OFS_EN_HIGH, 32'h0);
      en = 32'h11;
      dly <= 4'h0;
      @(posedge clock_i) idl <= 1'b1;
      @(posedge clock_i) idl <= 1'b0;
      fire(27'h40, 1'b0);
      repeat (4) @(negedge clock_i);
      chk(32'(idle), 32'h1);
      rdc(OFS_STATUS, 32'h80);
      fire(27'h10, 1'b0);
      for (k = 0; k < 20 && wake !== 1'b1; k++) @(negedge clock_i);
      chk(32'(wake), 32'h1);
      chk(32'(idle), 32'h0);
      drain;
      @(posedge clock_i) idl <= 1'b1;
      @(posedge clock_i) idl <= 1'b0;
      @(negedge clock_i) chk(32'(idle), 32'h1);
      @(posedge clock_i);
      rst_i <= 1'b1;
      @(posedge clock_i) rst_i <= 1'b0;
      @(negedge clock_i) chk(32'(idle), 32'h0);
      pend = 32'h1;
      en = 32'h1;
      {dbase, hbase} = '0;
      drain;
      rdc(OFS_FLAGS_LOW, 32'h0);
      @(posedge clock_i) srst <= 1'b1;
      @(posedge clock_i) srst <= 1'b0;
      pend = 32'h1;
      drain;
      end_sim;
   end
endmodule
`default_nettype wire
